// ===== srpc_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// configuration from the register bank to the pulse generator, status back
interface srpc_cfg_if;
	logic gen_enable; // pulse generation on
	logic repeater_mode_select; // request driven when high
	logic burst_on_request_enable; // master mode bursts on request
	logic [2:0] interp_input_prescaler; // prescaler ratio
	logic [10:0] pulse_freq_divider; // pulse frequency divider
	logic [3:0] burst_pulse_count; // pulses per burst
	logic ignore_input_pins; // request pin ignore
	logic phase_sync_enable; // phase sync in use
	logic [3:0] burst_left; // pulses still owed
	logic busy; // burst in progress
	modport ctrl (output gen_enable, repeater_mode_select, burst_on_request_enable, interp_input_prescaler,
		pulse_freq_divider, burst_pulse_count, ignore_input_pins, phase_sync_enable, input burst_left, busy);
	modport gen (input gen_enable, repeater_mode_select, burst_on_request_enable, interp_input_prescaler,
		pulse_freq_divider, burst_pulse_count, ignore_input_pins, phase_sync_enable, output burst_left, busy);
endinterface : srpc_cfg_if
`default_nettype wire

// ===== srpc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side converter model: it only listens to the pulse line and keeps pulse statistics
module srpc_conv_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pulse_in,
	output int now_cyc,
	output int pulse_total,
	output int last_at,
	output int last_gap,
	output int wide_count
);
	logic prev_q; // pulse line one cycle ago
	////////////////////////////////////////////////////////////////
	// free cycle counter, the time base for gaps and latencies
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			now_cyc <= 0;
		end else begin
			now_cyc <= now_cyc + 1;
		end
	end
	////////////////////////////////////////////////////////////////
	// pulse count, arrival cycle and spacing of the last two pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_total <= 0;
			last_at <= 0;
			last_gap <= 0;
		end else if (pulse_in === 1'b1) begin
			pulse_total <= pulse_total + 1;
			last_at <= now_cyc;
			last_gap <= now_cyc - last_at;
		end
	end
	////////////////////////////////////////////////////////////////
	// a converter latches on level, so a pulse wider than one cycle is counted as a fault
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 1'b0;
			wide_count <= 0;
		end else begin
			prev_q <= pulse_in;
			if (prev_q === 1'b1 && pulse_in === 1'b1) begin
				wide_count <= wide_count + 1;
			end
		end
	end
endmodule : srpc_conv_model
`default_nettype wire

// ===== srpc_delay_line.sv
`timescale 1ns/1ps
`default_nettype none
// programmable delay of a one-cycle pulse, latency sel plus one cycle
module srpc_delay_line #(
	parameter int DEPTH = 256,
	parameter int SEL_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic pulse_in,
	input wire logic [SEL_W-1:0] sel,
	output logic pulse_out_q
);
	logic [DEPTH-1:0] sr_q; // history of the input
	logic tap; // selected history bit

	// zero delay bypasses the shift register
	assign tap = (sel == '0) ? pulse_in : sr_q[SEL_W'(sel - 1'b1)];

	// shift history; changing sel mid-flight may drop or double a pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_q <= '0;
		end else if (ce) begin
			sr_q <= {sr_q[DEPTH-2:0], pulse_in};
		end
	end

	// registered output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_out_q <= 1'b0;
		end else if (ce) begin
			pulse_out_q <= tap;
		end
	end

	property p_zero_delay;
		@(posedge pclk) disable iff (!presetn)
		(ce && sel == '0) |=> (pulse_out_q == $past(pulse_in));
	endproperty
	a_zero_delay: assert property (p_zero_delay) else $error("zero delay does not pass pulse");
endmodule : srpc_delay_line
`default_nettype wire

// ===== srpc_pkg.sv
// shared constants of the sync reference pulse control block
package srpc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] SRPC_IDX_MODE = 8'h47;
	localparam logic [7:0] SRPC_IDX_DIVC = 8'h48;
	localparam logic [7:0] SRPC_IDX_STEPL = 8'h49;
	localparam logic [7:0] SRPC_IDX_STEPH = 8'h4a;
	localparam logic [7:0] SRPC_IDX_CHD = 8'h4b;
	localparam logic [7:0] SRPC_IDX_IGN = 8'h3a;
	localparam logic [7:0] SRPC_IDX_PSYNC = 8'h40;
	localparam logic [7:0] SRPC_IDX_STAT = 8'h41;
	// field positions
	localparam int SRPC_PRE_LSB = 5;
	localparam int SRPC_PRE_W = 3;
	localparam int SRPC_BURST_BIT = 4;
	localparam int SRPC_EN_BIT = 3;
	localparam int SRPC_REP_BIT = 2;
	localparam int SRPC_DIV_W = 11;
	localparam int SRPC_STEP_W = 6;
	localparam int SRPC_STEP2_LSB = 6;
	localparam int SRPC_CNT_LSB = 12;
	localparam int SRPC_CNT_W = 4;
	localparam int SRPC_CHD_LSB = 6;
	localparam int SRPC_CHD_W = 5;
	localparam int SRPC_IGN_BIT = 15;
	localparam int SRPC_PSYNC_BIT = 0;
	localparam int SRPC_STAT_BUSY_BIT = 4;
	// writable bits per register
	localparam logic [15:0] SRPC_MASK_MODE = 16'h00fc;
	localparam logic [15:0] SRPC_MASK_DIVC = 16'h07ff;
	localparam logic [15:0] SRPC_MASK_STEPL = 16'h0fff;
	localparam logic [15:0] SRPC_MASK_STEPH = 16'hffff;
	localparam logic [15:0] SRPC_MASK_CHD = 16'h07c0;
	localparam logic [15:0] SRPC_MASK_IGN = 16'h8000;
	localparam logic [15:0] SRPC_MASK_PSYNC = 16'h0001;
	// reset values
	localparam logic [15:0] SRPC_RST_MODE = 16'h0080;
	localparam logic [15:0] SRPC_RST_DIVC = 16'h0001;
	localparam logic [15:0] SRPC_RST_STEPL = 16'h003f;
	localparam logic [15:0] SRPC_RST_STEPH = 16'h0000;
	localparam logic [15:0] SRPC_RST_CHD = 16'h0000;
	localparam logic [15:0] SRPC_RST_IGN = 16'h8000;
	localparam logic [15:0] SRPC_RST_PSYNC = 16'h0000;
endpackage : srpc_pkg

// ===== srpc_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
// prescaler, frequency divider and burst logic of the pulse generator
module srpc_pulse_gen
	import srpc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic pulse_request_pin,
	srpc_cfg_if.gen cfg,
	output logic pulse_q
);
	logic req_prev_q; // last qualified request level
	logic [2:0] pre_cnt_q; // prescaler phase
	logic [10:0] div_cnt_q; // divider phase
	logic [3:0] left_q; // pulses still owed
	logic ignore; // pins masked
	logic req_eff; // qualified request
	logic rise; // request rising edge
	logic pre_tick; // prescaler wrap
	logic tick; // pulse slot
	logic burst_mode; // request driven generation
	logic [2:0] pre_lim; // prescaler terminal count
	logic [10:0] div_lim; // divider terminal count

	assign ignore = cfg.ignore_input_pins & ~cfg.phase_sync_enable;
	assign req_eff = pulse_request_pin & ~ignore;
	assign rise = req_eff & ~req_prev_q;
	// a ratio of zero is treated as one so the chain never stalls
	assign pre_lim = (cfg.interp_input_prescaler == 3'h0) ? 3'h0 : 3'(cfg.interp_input_prescaler - 3'h1);
	assign div_lim = (cfg.pulse_freq_divider == 11'h000) ? 11'h000 : 11'(cfg.pulse_freq_divider - 11'h001);
	// at or past the limit wraps at once, so lowering a ratio in flight never runs the 11-bit count round
	assign pre_tick = (pre_cnt_q >= pre_lim);
	assign tick = pre_tick & (div_cnt_q >= div_lim);
	assign burst_mode = cfg.repeater_mode_select | cfg.burst_on_request_enable;
	assign cfg.burst_left = left_q;
	assign cfg.busy = (left_q != 4'h0);

	// request edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_prev_q <= 1'b0;
		end else if (ce) begin
			req_prev_q <= req_eff;
		end
	end

	// prescaler then divider; both hold at zero while disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt_q <= 3'h0;
			div_cnt_q <= 11'h000;
		end else if (ce) begin
			if (!cfg.gen_enable) begin
				pre_cnt_q <= 3'h0;
				div_cnt_q <= 11'h000;
			end else if (pre_tick) begin
				pre_cnt_q <= 3'h0;
				div_cnt_q <= (div_cnt_q >= div_lim) ? 11'h000 : 11'(div_cnt_q + 11'h001);
			end else begin
				pre_cnt_q <= 3'(pre_cnt_q + 3'h1);
			end
		end
	end

	// burst bookkeeping; a new request restarts the burst
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q <= 4'h0;
		end else if (ce) begin
			if (!cfg.gen_enable) begin
				left_q <= 4'h0;
			end else if (rise && burst_mode) begin
				left_q <= cfg.burst_pulse_count;
			end else if (tick && left_q != 4'h0) begin
				left_q <= 4'(left_q - 4'h1);
			end
		end
	end

	// pulse slot: continuous in plain master mode, else only while owed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_q <= 1'b0;
		end else if (ce) begin
			pulse_q <= cfg.gen_enable & tick & (burst_mode ? (left_q != 4'h0) : 1'b1);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_req_rise;
		ce && cfg.gen_enable && rise && burst_mode;
	endsequence
	sequence s_owed_slot;
		ce && cfg.gen_enable && cfg.burst_on_request_enable && !cfg.repeater_mode_select && tick && left_q != 4'h0 && !rise;
	endsequence
	property p_burst_load;
		s_req_rise |=> (left_q == $past(cfg.burst_pulse_count));
	endproperty
	a_burst_load: assert property (p_burst_load) else $error("burst count not loaded");
	property p_master_burst;
		s_owed_slot |=> (pulse_q && left_q == 4'($past(left_q) - 4'h1));
	endproperty
	a_master_burst: assert property (p_master_burst) else $error("burst pulse missing");
	property p_master_cont;
		(ce && cfg.gen_enable && !burst_mode && tick) |=> pulse_q;
	endproperty
	a_master_cont: assert property (p_master_cont) else $error("continuous pulse missing");
	property p_repeat_idle;
		(ce && cfg.repeater_mode_select && left_q == 4'h0) |=> !pulse_q;
	endproperty
	a_repeat_idle: assert property (p_repeat_idle) else $error("pulse without request");
	property p_ignore;
		(ce && ignore && left_q == 4'h0) |=> (left_q == 4'h0);
	endproperty
	a_ignore: assert property (p_ignore) else $error("ignored pin started burst");
endmodule : srpc_pulse_gen
`default_nettype wire

// ===== srpc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - three-bit interpolator prescaler, resets to four
// - master burst: counted pulses per request rise
// - repeater and burst bits clear: continuous master pulses
// - repeater bit set: pulses only on request
// - eleven-bit pulse frequency divider, resets to one
// - four six-bit delay steps, first resets ones
// - four-bit burst count, resets to zero
// - five-bit channel divider select, resets zero
// - ignore bit masks pins without phase sync
module srpc_top
	import srpc_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int DELAY_DEPTH = 256
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pulse_request_pin,
	output logic pulse_out,
	output logic [4:0] output_chain_divide_select
);
	////////////////////////////////////////////////////////////////////////
	// register state
	logic [15:0] mode_q; // prescaler, burst, enable, repeater
	logic [15:0] divc_q; // pulse frequency divider
	logic [15:0] stepl_q; // delay steps one and two
	logic [15:0] steph_q; // delay steps three, four, burst count
	logic [15:0] chd_q; // channel divider select
	logic [15:0] ign_q; // pin ignore
	logic [15:0] psync_q; // phase sync enable
	logic pready_q; // answer flag
	logic pslverr_q; // error answer
	logic [31:0] prdata_q; // read data
	logic access; // access phase cycle
	logic fire; // transfer completes this edge
	logic wr_fire; // write completes this edge
	logic [7:0] idx; // word index of paddr
	logic hit; // mapped index
	logic [15:0] rd_val; // selected read value
	logic gen_pulse; // undelayed pulse
	logic [7:0] delay_sel; // summed delay steps
	logic [15:0] stat_val; // live status word

	srpc_cfg_if cfg ();

	////////////////////////////////////////////////////////////////////////
	// helpers
	// merge the two low byte lanes; upper lanes have no storage
	function automatic logic [15:0] srpc_merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] v;
		v = old;
		if (strb[0]) begin
			v[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			v[15:8] = wd[15:8];
		end
		return v & mask;
	endfunction : srpc_merge

	// write strobe for one register index
	function automatic logic srpc_wr_hit(input logic w, input logic [7:0] i, input logic [7:0] target);
		return w && (i == target);
	endfunction : srpc_wr_hit

	////////////////////////////////////////////////////////////////////////
	// bus decode
	assign access = psel & penable;
	assign fire = access & pready_q;
	assign wr_fire = fire & pwrite & ~pslverr_q;
	// low two address bits are ignored; bits above the index must be zero
	assign idx = paddr[9:2];
	assign stat_val = {11'h000, cfg.busy, cfg.burst_left};

	// read mux and address decode
	always_comb begin
		hit = 1'b1;
		rd_val = 16'h0000;
		if (paddr[ADDR_W-1:10] != '0) begin
			hit = 1'b0;
		end else begin
			unique case (idx)
				SRPC_IDX_MODE: rd_val = mode_q;
				SRPC_IDX_DIVC: rd_val = divc_q;
				SRPC_IDX_STEPL: rd_val = stepl_q;
				SRPC_IDX_STEPH: rd_val = steph_q;
				SRPC_IDX_CHD: rd_val = chd_q;
				SRPC_IDX_IGN: rd_val = ign_q;
				SRPC_IDX_PSYNC: rd_val = psync_q;
				SRPC_IDX_STAT: rd_val = stat_val;
				default: hit = 1'b0; // unmapped index
			endcase
		end
	end

	// one wait state: answer in the second access cycle, gives a full cycle for decode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (ce) begin
			if (access && !pready_q) begin
				pready_q <= 1'b1;
				pslverr_q <= ~hit;
				prdata_q <= (hit && !pwrite) ? {16'h0000, rd_val} : 32'h0000_0000;
			end else begin
				pready_q <= 1'b0;
				pslverr_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers, written at the completing edge only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= SRPC_RST_MODE;
			divc_q <= SRPC_RST_DIVC;
		end else if (ce) begin
			if (srpc_wr_hit(wr_fire, idx, SRPC_IDX_MODE)) begin
				mode_q <= srpc_merge(mode_q, pwdata, pstrb, SRPC_MASK_MODE);
			end
			if (srpc_wr_hit(wr_fire, idx, SRPC_IDX_DIVC)) begin
				divc_q <= srpc_merge(divc_q, pwdata, pstrb, SRPC_MASK_DIVC);
			end
		end
	end

	// delay steps and burst count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stepl_q <= SRPC_RST_STEPL;
			steph_q <= SRPC_RST_STEPH;
		end else if (ce) begin
			if (srpc_wr_hit(wr_fire, idx, SRPC_IDX_STEPL)) begin
				stepl_q <= srpc_merge(stepl_q, pwdata, pstrb, SRPC_MASK_STEPL);
			end
			if (srpc_wr_hit(wr_fire, idx, SRPC_IDX_STEPH)) begin
				steph_q <= srpc_merge(steph_q, pwdata, pstrb, SRPC_MASK_STEPH);
			end
		end
	end

	// channel divider select, pin ignore, phase sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chd_q <= SRPC_RST_CHD;
			ign_q <= SRPC_RST_IGN;
			psync_q <= SRPC_RST_PSYNC;
		end else if (ce) begin
			if (srpc_wr_hit(wr_fire, idx, SRPC_IDX_CHD)) begin
				chd_q <= srpc_merge(chd_q, pwdata, pstrb, SRPC_MASK_CHD);
			end
			if (srpc_wr_hit(wr_fire, idx, SRPC_IDX_IGN)) begin
				ign_q <= srpc_merge(ign_q, pwdata, pstrb, SRPC_MASK_IGN);
			end
			if (srpc_wr_hit(wr_fire, idx, SRPC_IDX_PSYNC)) begin
				psync_q <= srpc_merge(psync_q, pwdata, pstrb, SRPC_MASK_PSYNC);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fields to the generator
	assign cfg.gen_enable = mode_q[SRPC_EN_BIT];
	assign cfg.repeater_mode_select = mode_q[SRPC_REP_BIT];
	assign cfg.burst_on_request_enable = mode_q[SRPC_BURST_BIT];
	assign cfg.interp_input_prescaler = mode_q[SRPC_PRE_LSB +: SRPC_PRE_W];
	assign cfg.pulse_freq_divider = divc_q[SRPC_DIV_W-1:0];
	assign cfg.burst_pulse_count = steph_q[SRPC_CNT_LSB +: SRPC_CNT_W];
	assign cfg.ignore_input_pins = ign_q[SRPC_IGN_BIT];
	assign cfg.phase_sync_enable = psync_q[SRPC_PSYNC_BIT];
	// total delay is the sum of the four steps
	assign delay_sel = 8'(stepl_q[SRPC_STEP_W-1:0]) + 8'(stepl_q[SRPC_STEP2_LSB +: SRPC_STEP_W])
		+ 8'(steph_q[SRPC_STEP_W-1:0]) + 8'(steph_q[SRPC_STEP2_LSB +: SRPC_STEP_W]);

	srpc_pulse_gen u_gen (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.pulse_request_pin(pulse_request_pin),
		.cfg(cfg.gen),
		.pulse_q(gen_pulse)
	);

	srpc_delay_line #(
		.DEPTH(DELAY_DEPTH),
		.SEL_W(8)
	) u_dly (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.pulse_in(gen_pulse),
		.sel(delay_sel),
		.pulse_out_q(pulse_out)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign output_chain_divide_select = chd_q[SRPC_CHD_LSB +: SRPC_CHD_W];

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_access_wait;
		ce && access && !pready_q;
	endsequence
	sequence s_word_write(logic [7:0] target);
		ce && wr_fire && idx == target && pstrb[1:0] == 2'b11;
	endsequence

	property p_answer;
		s_access_wait |=> pready_q;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer after wait state");
	property p_read_steps;
		(s_access_wait and (idx == SRPC_IDX_STEPL && !pwrite && paddr[ADDR_W-1:10] == '0))
			|=> (pready_q && prdata_q[11:0] == $past(stepl_q[11:0]) && prdata_q[31:12] == '0);
	endproperty
	a_read_steps: assert property (p_read_steps) else $error("delay step readback wrong");
	property p_prescaler_wr;
		s_word_write(SRPC_IDX_MODE) |=> (cfg.interp_input_prescaler == $past(pwdata[7:5]));
	endproperty
	a_prescaler_wr: assert property (p_prescaler_wr) else $error("prescaler not written");
	property p_divider_wr;
		s_word_write(SRPC_IDX_DIVC) |=> (cfg.pulse_freq_divider == $past(pwdata[10:0]) && divc_q[15:11] == '0);
	endproperty
	a_divider_wr: assert property (p_divider_wr) else $error("divider not written");
	property p_count_wr;
		s_word_write(SRPC_IDX_STEPH) |=> (cfg.burst_pulse_count == $past(pwdata[15:12]));
	endproperty
	a_count_wr: assert property (p_count_wr) else $error("burst count not written");
	property p_chain_wr;
		s_word_write(SRPC_IDX_CHD) |=> (output_chain_divide_select == $past(pwdata[10:6]) && chd_q[5:0] == '0);
	endproperty
	a_chain_wr: assert property (p_chain_wr) else $error("channel divider select not written");
	property p_mode_hold;
		(ce && !wr_fire) |=> (mode_q == $past(mode_q));
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed without write");
endmodule : srpc_top
`default_nettype wire

// ===== test_sync_reference_pulse_control.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench of the pulse control register bank and generator
module test_sync_reference_pulse_control;
	logic pclk, presetn, ce, psel, penable, pwrite, req, pready, pslverr, pulse_out;
	logic [11:0] paddr; // byte address
	logic [31:0] pwdata, prdata, rd, wr_data; // wr_data is a random word before it is driven
	logic [3:0] pstrb, wr_strb; // wr_strb is a random strobe before it is driven
	logic [4:0] chd_out; // channel divider select port
	logic err, ce_jitter;
	int failures, check_count, now_cyc, pulse_total, last_at, last_gap, wide_count, base, t0, k, d, lat0, sum;
	logic [15:0] shadow [5]; // expected register contents
	logic [15:0] masks [5] = '{16'h00fc, 16'h07ff, 16'h0fff, 16'hffff, 16'h07c0};
	logic [11:0] addrs [5] = '{12'h11c, 12'h120, 12'h124, 12'h128, 12'h12c};
	srpc_top srpc_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pulse_request_pin(req), .pulse_out(pulse_out), .output_chain_divide_select(chd_out));
	srpc_conv_model srpc_conv_model_inst (.pclk(pclk), .presetn(presetn), .pulse_in(pulse_out),
		.now_cyc(now_cyc), .pulse_total(pulse_total), .last_at(last_at), .last_gap(last_gap),
		.wide_count(wide_count));
	////////////////////////////////////////////////////////////////
	// 250 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// clock enable jitter stretches bus answers without breaking them
	always @(posedge pclk) begin
		ce <= ce_jitter ? ($urandom_range(3, 0) != 0) : 1'b1;
	end
	////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	// one apb transfer; entered and left just after a rising edge, with an idle edge before return
	task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] wd, input logic [3:0] st);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, wd};
		pstrb <= st;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (!(pready === 1'b1 && ce === 1'b1) && n < 60); // a frozen edge completes nothing
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 60) begin
			failures++;
			$display("BAD %0t bus answer missing", $time);
			close_out();
		end
		@(posedge pclk);
	endtask : apb
	task automatic rchk(input logic [11:0] a, input logic [15:0] exp);
		apb(1'b0, a, 16'h0000, 4'h0);
		check(rd, {16'h0000, exp}, "read");
		check(err, 1'b0, "read error");
	endtask : rchk
	// mode register image: prescaler, burst enable, generator enable, repeater
	function automatic logic [15:0] mode_val(input int pre, input bit burst, input bit rep);
		return 16'((pre << 5) | (burst << 4) | 8 | (rep << 2));
	endfunction : mode_val
	// one request rise, held two cycles
	task automatic rise();
		req <= 1'b1;
		repeat (2) @(posedge pclk);
		req <= 1'b0;
		@(posedge pclk);
	endtask : rise
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, req, ce_jitter} = 6'b000000;
		{paddr, pwdata, pstrb} = '0;
		void'($urandom(32'hddaf));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		shadow = '{16'h0080, 16'h0001, 16'h003f, 16'h0000, 16'h0000};
		for (int i = 0; i < 5; i++) rchk(addrs[i], shadow[i]);
		rchk(12'h0e8, 16'h8000);
		rchk(12'h100, 16'h0000);
		rchk(12'h104, 16'h0000);
		check(chd_out, 5'h00, "divider select at reset");
		// random writes with lane strobes and clock enable jitter
		ce_jitter <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			k = $urandom_range(4, 0);
			wr_data = $urandom();
			wr_strb = 4'($urandom());
			apb(1'b1, addrs[k], wr_data[15:0], wr_strb);
			for (int b = 0; b < 2; b++) begin
				for (int j = 8 * b; j < 8 * b + 8; j++) begin
					if (wr_strb[b] && masks[k][j]) shadow[k][j] = wr_data[j];
				end
			end
			if (k == 4) check(chd_out, shadow[4][10:6], "divider select port");
		end
		for (int i = 0; i < 5; i++) rchk(addrs[i], shadow[i]);
		apb(1'b0, 12'h130, 16'h0000, 4'h0);
		check(err, 1'b1, "unmapped read error");
		check(rd, 32'h0, "unmapped read data");
		apb(1'b1, 12'h104, 16'hffff, 4'hf);
		check(err, 1'b0, "status write");
		ce_jitter <= 1'b0;
		// continuous master pulses: spacing is prescaler times divider, zero delay
		apb(1'b1, 12'h124, 16'h0000, 4'hf);
		apb(1'b1, 12'h128, 16'h0000, 4'hf);
		for (int p = 0; p < 9; p++) begin
			// a one-cycle period would hold the line high, which the converter counts as a fault
			k = (p == 8) ? 2047 : $urandom_range(4, 2);
			d = (p == 8) ? 1 : p;
			apb(1'b1, 12'h120, 16'(k), 4'hf);
			apb(1'b1, 12'h11c, mode_val(d, 0, 0), 4'hf);
			repeat (3 * k * (d == 0 ? 1 : d) + 10) @(posedge pclk);
			check(last_gap, k * (d == 0 ? 1 : d), "master spacing");
		end
		// repeater and master burst: counted pulses per request rise only
		// two-cycle slots keep burst pulses apart on the line
		apb(1'b1, 12'h120, 16'h0002, 4'hf);
		apb(1'b1, 12'h0e8, 16'h0000, 4'hf);
		for (int p = 0; p < 6; p++) begin
			k = (p == 0) ? 0 : (p == 1) ? 15 : $urandom_range(14, 1);
			apb(1'b1, 12'h128, 16'(k << 12), 4'hf);
			apb(1'b1, 12'h11c, mode_val(1, p[0], !p[0]), 4'hf);
			repeat (10) @(posedge pclk);
			base = pulse_total;
			repeat (20) @(posedge pclk);
			check(pulse_total - base, 0, "pulses without request");
			rise();
			repeat (40) @(posedge pclk);
			check(pulse_total - base, k, "burst size");
		end
		// ignore bit masks the pin unless phase sync is on
		// one-cycle slots make the request latency independent of slot phase
		apb(1'b1, 12'h120, 16'h0001, 4'hf);
		apb(1'b1, 12'h0e8, 16'h8000, 4'hf);
		base = pulse_total;
		rise();
		repeat (30) @(posedge pclk);
		check(pulse_total - base, 0, "ignored request");
		apb(1'b1, 12'h100, 16'h0001, 4'hf);
		apb(1'b1, 12'h128, 16'h1000, 4'hf);
		base = pulse_total;
		t0 = now_cyc;
		rise();
		repeat (30) @(posedge pclk);
		check(pulse_total - base, 1, "request with phase sync");
		lat0 = last_at - t0;
		// four delay steps add up on the pulse path
		for (int p = 0; p < 3; p++) begin
			wr_data = $urandom();
			sum = wr_data[5:0] + wr_data[11:6] + wr_data[17:12] + wr_data[23:18];
			apb(1'b1, 12'h124, wr_data[11:0], 4'hf);
			apb(1'b1, 12'h128, {4'h1, wr_data[23:12]}, 4'hf);
			t0 = now_cyc;
			rise();
			repeat (300) @(posedge pclk);
			check(last_at - t0, lat0 + sum, "delay latency");
		end
		check(wide_count, 0, "pulse width");
		close_out();
	end
endmodule : test_sync_reference_pulse_control
`default_nettype wire
